// ### rtl/panel_params.svh
// register map, field positions, reset values and light codes for the panel controller
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH

`define REG_CTRL_OFS     8'h00
`define REG_CH1_OFS      8'h04
`define REG_CH2_OFS      8'h08
`define REG_VOL_OFS      8'h0c
`define REG_STAT_OFS     8'h10

`define CTRL_MODE_BIT    0
`define CTRL_SELCH_BIT   1
`define CTRL_SELOUT_BIT  2
`define CTRL_MUTE_BIT    3
`define CTRL_LINK_BIT    4

`define CH_GAIN_LSB      0
`define CH_LINE_BIT      8
`define CH_FILT_BIT      9
`define CH_PHAN_BIT      10
`define CH_PAD_BIT       11
`define CH_POL_BIT       12

`define VOL_SPK_LSB      0
`define VOL_HP_LSB       8

`define STAT_JACK_BIT    0
`define STAT_SRC1_LSB    2
`define STAT_SRC2_LSB    4

`define LEVEL_W          6
`define LEVEL_MAX        6'h3f
`define LEVEL_MIN        6'h00
`define GAIN_RST         6'h00
`define VOL_RST          6'h00

`define LIGHT_OFF        2'h0
`define LIGHT_DIM        2'h1
`define LIGHT_BRIGHT     2'h2

`define HPF_CUTOFF_HZ    75
`define PAD_DB           20

`endif

// ### rtl/panel_pkg.sv
// types shared by the panel controller files
package panel_pkg;

	typedef enum logic [1:0] {
		MODE_PREAMP  = 2'b01,
		MODE_MONITOR = 2'b10
	} mode_t;

	typedef enum logic [1:0] {
		SRC_MIC  = 2'h0,
		SRC_LINE = 2'h1,
		SRC_INST = 2'h2
	} src_t;

	// stored per-channel settings
	typedef struct packed {
		logic [5:0] gain;
		logic       line_sel;
		logic       filter;
		logic       phantom;
		logic       pad;
		logic       polarity;
	} chan_cfg_t;

	// raw panel pins, bundled so one synchroniser serves them all
	typedef struct packed {
		logic       preamp_btn;
		logic       monitor_btn;
		logic       knob_push;
		logic       knob_cw;
		logic       knob_ccw;
		logic [5:0] opt_btn;
		logic       instrument_jack;
	} panel_t;

endpackage : panel_pkg

// ### rtl/pin_sync.sv
// two-flop synchroniser with rising-edge detect for panel pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// meta_q feeds only sync_q; edge detect looks at the settled copies
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
endmodule : pin_sync

// ### rtl/option_lights.sv
// option light codes for one channel: bright enabled, dim disabled, off unavailable
`timescale 1ns/1ps
`include "panel_params.svh"
module option_lights (
	input  wire panel_pkg::chan_cfg_t cfg,
	input  wire panel_pkg::src_t      src,
	input  wire logic                 link,
	input  wire logic                 jack,
	input  wire logic                 blank,
	output logic [11:0]               lights
);
	function automatic logic [1:0] code(input logic avail, input logic on);
		if (!avail)
			code = `LIGHT_OFF;
		else if (on)
			code = `LIGHT_BRIGHT;
		else
			code = `LIGHT_DIM;
	endfunction : code

	logic is_mic;
	assign is_mic = (src == panel_pkg::SRC_MIC);

	// whole display unlit in output mode
	always_comb begin
		lights = '0;
		if (!blank) begin
			lights[1:0]   = code(src != panel_pkg::SRC_INST, cfg.line_sel);
			lights[3:2]   = code(1'b1, cfg.filter);
			lights[5:4]   = code(is_mic, cfg.phantom);
			lights[7:6]   = code(is_mic, cfg.pad);
			lights[9:8]   = code(1'b1, cfg.polarity);
			lights[11:10] = code(!jack, link);
		end
	end
endmodule : option_lights

// ### rtl/front_panel_ctrl.sv
// front panel mode controller with APB register access
//
// Function
// - one of two modes; mode button selects it
// - gain-mode button again toggles selected channel
// - knob push in gain mode toggles channel
// - adjustments touch only selected channel unless linked
// - source button alternates mic and line
// - instrument plug forces channel one source
// - each channel has exactly one source
// - clockwise knob raises selected channel gain
// - six options, lights bright dim or off
// - output button enters mode, alternates outputs
// - knob changes only selected output volume
// - knob push toggles speaker mute only
// - mute turns ring and speaker light red
// - output mode ignores options, lights off
// - rumble cut switches in 75 Hz highpass
// - phantom power offered for microphone only
// - pad lowers mic 20 dB, mic only
// - polarity option inverts channel signal
// - linked pair applies adjustments to both
// - link refused while instrument plug inserted
// - ring shows selected gain or volume
// - host may write every setting anytime, except link while instrument plug inserted
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "panel_params.svh"
module front_panel_ctrl (
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire panel_pkg::panel_t     panel,
	output logic                       first_channel_light,
	output logic                       second_channel_light,
	output logic      [1:0]            ch1_source,
	output logic      [1:0]            ch2_source,
	output logic      [11:0]           option_light,
	output logic      [15:0]           ring_led,
	output logic                       ring_red,
	output logic                       spk_light_green,
	output logic                       spk_light_red,
	output logic                       hp_light,
	output logic      [5:0]            ch1_gain,
	output logic      [5:0]            ch2_gain,
	output logic      [1:0]            hpf_en,
	output logic      [1:0]            phantom_power,
	output logic      [1:0]            pad_en,
	output logic      [1:0]            invert_en,
	output logic      [5:0]            spk_volume,
	output logic      [5:0]            hp_volume,
	output logic                       spk_mute
);
	panel_pkg::panel_t    pan_lvl;
	panel_pkg::panel_t    pan_rise;
	panel_pkg::mode_t     mode_q;
	panel_pkg::chan_cfg_t cfg_q [2];
	panel_pkg::src_t      src   [2];
	logic                 sel_ch_q;
	logic                 sel_out_q;
	logic                 mute_q;
	logic                 link_q;
	logic [5:0]           spk_q;
	logic [5:0]           hp_q;
	logic [31:0]          rdata_q;
	logic                 jack;
	logic                 pre_mode;
	logic                 mon_mode;
	logic                 knob_move;
	logic                 apb_wr;
	logic                 wr_ctrl;
	logic                 wr_vol;
	logic [1:0]           wr_ch;
	logic                 addr_ok;
	logic [5:0]           ring_val;

	// saturating knob step, shared by gains and volumes; opposite detents in one cycle cancel
	function automatic logic [5:0] step(input logic [5:0] v, input logic up, input logic dn);
		if (up && !dn && v != `LEVEL_MAX)
			step = v + 6'h01;
		else if (dn && !up && v != `LEVEL_MIN)
			step = v - 6'h01;
		else
			step = v;
	endfunction : step

	function automatic logic [31:0] cfg_word(input panel_pkg::chan_cfg_t c);
		cfg_word = '0;
		cfg_word[`CH_GAIN_LSB +: 6] = c.gain;
		cfg_word[`CH_LINE_BIT]      = c.line_sel;
		cfg_word[`CH_FILT_BIT]      = c.filter;
		cfg_word[`CH_PHAN_BIT]      = c.phantom;
		cfg_word[`CH_PAD_BIT]       = c.pad;
		cfg_word[`CH_POL_BIT]       = c.polarity;
	endfunction : cfg_word

	// every pin is asynchronous to the clock
	pin_sync #(.W($bits(panel_pkg::panel_t))) u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin     (panel),
		.level   (pan_lvl),
		.rise    (pan_rise)
	);

	assign jack      = pan_lvl.instrument_jack;
	assign pre_mode  = (mode_q == panel_pkg::MODE_PREAMP);
	assign mon_mode  = (mode_q == panel_pkg::MODE_MONITOR);
	assign knob_move = pan_rise.knob_cw | pan_rise.knob_ccw;

	// apb decode; zero wait states, writes land in the access cycle
	assign addr_ok = (paddr == `REG_CTRL_OFS) || (paddr == `REG_CH1_OFS) ||
	                 (paddr == `REG_CH2_OFS) || (paddr == `REG_VOL_OFS) ||
	                 (paddr == `REG_STAT_OFS);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign apb_wr  = psel & penable & pwrite;
	assign wr_ctrl = apb_wr & (paddr == `REG_CTRL_OFS);
	assign wr_ch   = {apb_wr & (paddr == `REG_CH2_OFS), apb_wr & (paddr == `REG_CH1_OFS)};
	assign wr_vol  = apb_wr & (paddr == `REG_VOL_OFS);
	assign prdata  = rdata_q;

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (psel && !penable && !pwrite) begin
			rdata_q <= '0;
			case (paddr)
				`REG_CTRL_OFS: begin
					rdata_q[`CTRL_MODE_BIT]   <= mon_mode;
					rdata_q[`CTRL_SELCH_BIT]  <= sel_ch_q;
					rdata_q[`CTRL_SELOUT_BIT] <= sel_out_q;
					rdata_q[`CTRL_MUTE_BIT]   <= mute_q;
					rdata_q[`CTRL_LINK_BIT]   <= link_q;
				end
				`REG_CH1_OFS: rdata_q <= cfg_word(cfg_q[0]);
				`REG_CH2_OFS: rdata_q <= cfg_word(cfg_q[1]);
				`REG_VOL_OFS: begin
					rdata_q[`VOL_SPK_LSB +: 6] <= spk_q;
					rdata_q[`VOL_HP_LSB +: 6]  <= hp_q;
				end
				`REG_STAT_OFS: begin
					rdata_q[`STAT_JACK_BIT]     <= jack;
					rdata_q[`STAT_SRC1_LSB +: 2] <= src[0];
					rdata_q[`STAT_SRC2_LSB +: 2] <= src[1];
				end
				default: rdata_q <= '0;
			endcase
		end
	end

	// operating mode; host write wins over a panel press in the same cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			mode_q <= panel_pkg::MODE_PREAMP;
		else if (wr_ctrl)
			mode_q <= pwdata[`CTRL_MODE_BIT] ? panel_pkg::MODE_MONITOR
			                                  : panel_pkg::MODE_PREAMP;
		else if (pan_rise.monitor_btn)
			mode_q <= panel_pkg::MODE_MONITOR;
		else if (pan_rise.preamp_btn)
			mode_q <= panel_pkg::MODE_PREAMP;
	end

	// selected channel: mode button or knob push while already in gain mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			sel_ch_q <= 1'b0;
		else if (wr_ctrl)
			sel_ch_q <= pwdata[`CTRL_SELCH_BIT];
		else if (pre_mode && !pan_rise.monitor_btn &&
		         (pan_rise.preamp_btn || pan_rise.knob_push))
			sel_ch_q <= ~sel_ch_q;
	end

	// selected output alternates only on presses made in output mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			sel_out_q <= 1'b0;
		else if (wr_ctrl)
			sel_out_q <= pwdata[`CTRL_SELOUT_BIT];
		else if (mon_mode && pan_rise.monitor_btn)
			sel_out_q <= ~sel_out_q;
	end

	// speaker mute; headphone selection never reaches it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			mute_q <= 1'b0;
		else if (wr_ctrl)
			mute_q <= pwdata[`CTRL_MUTE_BIT];
		else if (mon_mode && !sel_out_q && pan_rise.knob_push)
			mute_q <= ~mute_q;
	end

	// stereo pairing, dropped and refused while the instrument plug is in
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			link_q <= 1'b0;
		else if (jack)
			link_q <= 1'b0;
		else if (wr_ctrl)
			link_q <= pwdata[`CTRL_LINK_BIT];
		else if (pre_mode && pan_rise.opt_btn[5])
			link_q <= ~link_q;
	end

	// per-channel settings; panel edits hit the selected channel, or both when linked
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic hit;
		logic is_mic;
		assign hit    = pre_mode && (sel_ch_q == 1'(i) || link_q);
		assign is_mic = (src[i] == panel_pkg::SRC_MIC);

		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				cfg_q[i] <= '{gain: `GAIN_RST, default: 1'b0};
			end else if (wr_ch[i]) begin
				cfg_q[i].gain     <= pwdata[`CH_GAIN_LSB +: 6];
				cfg_q[i].line_sel <= pwdata[`CH_LINE_BIT];
				cfg_q[i].filter   <= pwdata[`CH_FILT_BIT];
				cfg_q[i].phantom  <= pwdata[`CH_PHAN_BIT];
				cfg_q[i].pad      <= pwdata[`CH_PAD_BIT];
				cfg_q[i].polarity <= pwdata[`CH_POL_BIT];
			end else if (hit) begin
				cfg_q[i].gain <= step(cfg_q[i].gain, pan_rise.knob_cw, pan_rise.knob_ccw);
				if (pan_rise.opt_btn[0])
					cfg_q[i].line_sel <= ~cfg_q[i].line_sel;
				if (pan_rise.opt_btn[1])
					cfg_q[i].filter <= ~cfg_q[i].filter;
				if (pan_rise.opt_btn[2] && is_mic)
					cfg_q[i].phantom <= ~cfg_q[i].phantom;
				if (pan_rise.opt_btn[3] && is_mic)
					cfg_q[i].pad <= ~cfg_q[i].pad;
				if (pan_rise.opt_btn[4])
					cfg_q[i].polarity <= ~cfg_q[i].polarity;
			end
		end

		// processing controls; phantom and pad only reach a microphone
		assign hpf_en[i]        = cfg_q[i].filter;
		assign phantom_power[i] = cfg_q[i].phantom & is_mic;
		assign pad_en[i]        = cfg_q[i].pad & is_mic;
		assign invert_en[i]     = cfg_q[i].polarity;
	end

	// one source per channel; the instrument jack overrides channel one only
	assign src[0] = jack ? panel_pkg::SRC_INST :
	                (cfg_q[0].line_sel ? panel_pkg::SRC_LINE : panel_pkg::SRC_MIC);
	assign src[1] = cfg_q[1].line_sel ? panel_pkg::SRC_LINE : panel_pkg::SRC_MIC;
	assign ch1_source = src[0];
	assign ch2_source = src[1];
	assign ch1_gain   = cfg_q[0].gain;
	assign ch2_gain   = cfg_q[1].gain;

	// output volumes, each kept on its own
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			spk_q <= `VOL_RST;
			hp_q  <= `VOL_RST;
		end else if (wr_vol) begin
			spk_q <= pwdata[`VOL_SPK_LSB +: 6];
			hp_q  <= pwdata[`VOL_HP_LSB +: 6];
		end else if (mon_mode && !sel_out_q) begin
			spk_q <= step(spk_q, pan_rise.knob_cw, pan_rise.knob_ccw);
		end else if (mon_mode && sel_out_q) begin
			hp_q  <= step(hp_q, pan_rise.knob_cw, pan_rise.knob_ccw);
		end
	end
	assign spk_volume = spk_q;
	assign hp_volume  = hp_q;
	assign spk_mute   = mute_q;

	// option display follows the selected channel; dark in output mode
	option_lights u_lights (
		.cfg    (cfg_q[sel_ch_q]),
		.src    (src[sel_ch_q]),
		.link   (link_q),
		.jack   (jack),
		.blank  (mon_mode),
		.lights (option_light)
	);

	// ring is a thermometer of the value the knob currently steers
	always_comb begin
		if (pre_mode)
			ring_val = cfg_q[sel_ch_q].gain;
		else
			ring_val = sel_out_q ? hp_q : spk_q;
		for (int k = 0; k < 16; k++)
			ring_led[k] = (ring_val > 6'(k * 4));
	end

	// red only while the muted speaker output is the one shown
	assign ring_red             = mute_q & mon_mode & ~sel_out_q;
	assign spk_light_green      = mon_mode & ~sel_out_q & ~mute_q;
	assign spk_light_red        = mon_mode & ~sel_out_q & mute_q;
	assign hp_light             = mon_mode & sel_out_q;
	assign first_channel_light  = pre_mode & ~sel_ch_q;
	assign second_channel_light = pre_mode & sel_ch_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence out_press_s;
		pan_rise.monitor_btn && !wr_ctrl;
	endsequence

	// a knob press that mutes the shown speaker output, with no competing press
	sequence spk_mute_push_s;
		mon_mode && !sel_out_q && !mute_q && pan_rise.knob_push && !wr_ctrl &&
		!pan_rise.monitor_btn && !pan_rise.preamp_btn;
	endsequence

	mode_enter_a: assert property (out_press_s |=> mon_mode)
		else $error("output button did not enter output mode");
	ch_toggle_a: assert property (pre_mode && !wr_ctrl && !pan_rise.monitor_btn &&
		(pan_rise.preamp_btn || pan_rise.knob_push) |=> sel_ch_q != $past(sel_ch_q))
		else $error("channel selection did not toggle");
	jack_src_a: assert property (jack |-> src[0] == panel_pkg::SRC_INST &&
		src[1] != panel_pkg::SRC_INST)
		else $error("instrument source wrong");
	mute_push_a: assert property (mon_mode && !sel_out_q && pan_rise.knob_push &&
		!wr_ctrl |=> mute_q != $past(mute_q))
		else $error("speaker mute did not toggle");
	hp_nomute_a: assert property (mon_mode && sel_out_q && !wr_ctrl |=>
		mute_q == $past(mute_q))
		else $error("mute changed on headphone selection");
	lights_off_a: assert property (mon_mode |-> option_light == 12'h000)
		else $error("option lights lit in output mode");
	link_refused_a: assert property (jack |=> !link_q)
		else $error("link held while instrument plugged");
	phantom_mic_a: assert property (phantom_power[0] |-> src[0] == panel_pkg::SRC_MIC)
		else $error("phantom power on non-mic source");
	vol_split_a: assert property (mon_mode && !sel_out_q && knob_move && !wr_vol |=>
		hp_q == $past(hp_q))
		else $error("headphone volume moved while speaker selected");
	gain_sat_a: assert property (pre_mode && !sel_ch_q && !wr_ch[0] &&
		cfg_q[0].gain == `LEVEL_MAX && pan_rise.knob_cw |=> cfg_q[0].gain == `LEVEL_MAX)
		else $error("gain wrapped at maximum");
	ring_red_a: assert property (spk_mute_push_s |=> ring_red && spk_light_red &&
		!spk_light_green)
		else $error("ring or speaker light not red after mute");
endmodule : front_panel_ctrl

// ### tb/panel_operator.sv
// operator model: presses panel buttons, turns the knob, plugs the instrument jack
`timescale 1ns/1ps
module panel_operator (
	input  wire logic         clock,
	output panel_pkg::panel_t panel
);
	logic [11:0] pins = 12'h000;

	// the struct is packed msb first, so bit 0 is the jack and bit 11 the gain-mode button
	assign panel = panel_pkg::panel_t'(pins);

	// one press or detent; held three clocks and released four so the two-flop
	// synchroniser sees a clean edge and the action has landed on return
	task automatic press(input int idx);
		pins[idx] <= 1'b1;
		repeat (3) @(posedge clock);
		pins[idx] <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : press

	// jack is a level, not an event; give the synchroniser time to settle
	task automatic set_jack(input logic v);
		pins[0] <= v;
		repeat (5) @(posedge clock);
	endtask : set_jack
endmodule : panel_operator

// ### tb/testbench.sv
// self-checking bench for the front panel controller
`timescale 1ns/1ps
`include "panel_params.svh"
module testbench;
	localparam int k_pre = 11;
	localparam int k_mon = 10;
	localparam int k_push = 9;
	localparam int k_cw = 8;
	localparam int k_ccw = 7;
	localparam int k_opt = 1;
	logic              clock = 1'b0;
	logic              sys_rst = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready, pslverr, l1, l2, ring_red, spk_g, spk_r, hp_light, spk_mute;
	logic [1:0]        src1, src2, hpf_en, phantom_power, pad_en, invert_en;
	logic [11:0]       opt_light;
	logic [15:0]       ring_led;
	logic [5:0]        g1, g2, spk_vol, hp_vol;
	panel_pkg::panel_t panel;
	int                n_errors = 0;
	int                cmp_count = 0;

	always #4 clock = ~clock;

	panel_operator op (.clock(clock), .panel(panel));

	front_panel_ctrl dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .panel(panel), .first_channel_light(l1),
		.second_channel_light(l2), .ch1_source(src1), .ch2_source(src2),
		.option_light(opt_light), .ring_led(ring_led), .ring_red(ring_red),
		.spk_light_green(spk_g), .spk_light_red(spk_r), .hp_light(hp_light),
		.ch1_gain(g1), .ch2_gain(g2), .hpf_en(hpf_en), .phantom_power(phantom_power),
		.pad_en(pad_en), .invert_en(invert_en), .spk_volume(spk_vol), .hp_volume(hp_vol),
		.spk_mute(spk_mute));

	task automatic finish_test();
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	// one apb transfer; the request stands until pready is seen, then an idle edge follows
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (n > 16) begin
				n_errors++;
				finish_test();
			end
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
		chk(e, 1'b0);
	endtask : rd

	// reset state, read-only status, unmapped address, host volume write
	task automatic s_reset_regs();
		logic [31:0] q;
		logic        e;
		chk(opt_light, 12'h555);
		chk(l1, 1'b1);
		rd(`REG_CTRL_OFS, 32'h0);
		wr(`REG_STAT_OFS, 32'hff);
		rd(`REG_STAT_OFS, 32'h0);
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk(e, 1'b1);
		chk(q, 32'h0);
		wr(`REG_VOL_OFS, 32'h0509);
		rd(`REG_VOL_OFS, 32'h0509);
	endtask : s_reset_regs

	// knob raises and lowers channel one gain, saturating at both ends
	task automatic s_gain();
		repeat (3) op.press(k_cw);
		chk(g1, 6'h03);
		chk(ring_led, 16'h0001);
		repeat (4) op.press(k_ccw);
		chk(g1, 6'h00);
		wr(`REG_CH1_OFS, 32'h3f);
		op.press(k_cw);
		chk(g1, 6'h3f);
		chk(ring_led, 16'hffff);
		wr(`REG_CH1_OFS, 32'h0);
	endtask : s_gain

	// channel toggles by button and by knob push; gain reaches only the selected channel
	task automatic s_channel();
		op.press(k_pre);
		chk({l1, l2}, 2'b01);
		op.press(k_cw);
		chk({g1, g2}, 12'h001);
		op.press(k_push);
		chk({l1, l2}, 2'b10);
		rd(`REG_CTRL_OFS, 32'h0);
	endtask : s_channel

	// source choice, availability of phantom and pad, and option lights on channel one
	task automatic s_options();
		op.press(k_opt);
		chk(src1, 2'h1);
		chk(opt_light, 12'h506);
		op.press(k_opt + 2);
		chk(phantom_power, 2'b00);
		rd(`REG_CH1_OFS, 32'h100);
		op.press(k_opt);
		for (int k = 1; k <= 4; k++)
			op.press(k_opt + k);
		chk(src1, 2'h0);
		chk(opt_light, 12'h6a9);
		chk({hpf_en, phantom_power, pad_en, invert_en}, 8'h55);
		rd(`REG_CH1_OFS, 32'h1e00);
		chk(src2, 2'h0);
	endtask : s_options

	// output mode: selection lights, volumes, mute on speaker only, options ignored
	task automatic s_output();
		op.press(k_mon);
		chk({l1, l2, spk_g, hp_light}, 4'b0010);
		chk(opt_light, 12'h000);
		op.press(k_opt + 1);
		chk(hpf_en, 2'b01);
		op.press(k_cw);
		chk({spk_vol, hp_vol}, 12'h285);
		chk(ring_led, 16'h0007);
		op.press(k_push);
		chk({spk_mute, ring_red, spk_r, spk_g}, 4'b1110);
		op.press(k_mon);
		chk(hp_light, 1'b1);
		op.press(k_push);
		chk(spk_mute, 1'b1);
		op.press(k_cw);
		chk({spk_vol, hp_vol}, 12'h286);
		op.press(k_mon);
		op.press(k_push);
		rd(`REG_CTRL_OFS, 32'h1);
		op.press(k_pre);
		chk({l1, l2, ring_red}, 3'b100);
	endtask : s_output

	// linked pair, then the instrument plug overrides channel one and drops the link
	task automatic s_link_jack();
		op.press(k_opt + 5);
		rd(`REG_CTRL_OFS, 32'h10);
		op.press(k_cw);
		chk({g1, g2}, 12'h042);
		op.set_jack(1'b1);
		chk({src1, src2}, 4'h8);
		chk(opt_light, 12'h208);
		chk(phantom_power, 2'b00);
		op.press(k_opt + 5);
		rd(`REG_CTRL_OFS, 32'h0);
		wr(`REG_CTRL_OFS, 32'h10);
		rd(`REG_CTRL_OFS, 32'h0);
		rd(`REG_STAT_OFS, 32'h9);
		op.set_jack(1'b0);
		chk({src1, phantom_power}, 4'h1);
		wr(`REG_CTRL_OFS, 32'h1f);
		rd(`REG_CTRL_OFS, 32'h1f);
		chk({hp_light, spk_mute, spk_r, ring_red, l2}, 5'b11000);
		wr(`REG_CH2_OFS, 32'h1f2a);
		rd(`REG_CH2_OFS, 32'h1f2a);
		chk({g2, src2}, 8'ha9);
		chk({hpf_en, phantom_power, pad_en, invert_en}, 8'hd7);
	endtask : s_link_jack

	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		s_reset_regs();
		s_gain();
		s_channel();
		s_options();
		s_output();
		s_link_jack();
		finish_test();
	end
endmodule : testbench
